// ===== src/sbc_event_status_flags.sv
// sticky event status flags, watchdog reset policy and host alert output
//
// Summary of operation
// RULE_01: watchdog overflow, or early trigger in window mode, sets failure flag
// RULE_02: window-mode watchdog failure requests system reset immediately
// RULE_03: timeout overflow resets only if flag already set
// RULE_04: auxiliary/external supply overvoltage sets supply bit 2
// RULE_05: auxiliary/external supply undervoltage sets supply bit 1
// RULE_06: main regulator undervoltage sets bit 0, never asleep
// RULE_07: main undervoltage capture ignores reset threshold setting
// RULE_08: selective wake frame error sets transceiver bit 5
// RULE_09: bus silence after enabled active bus sets bit 4
// RULE_10: transceiver deactivation sets bit 1, not in sleep
// RULE_11: bus wake-up while offline sets transceiver bit 0
// RULE_12: wake pin rising edge sets wake bit 1
// RULE_13: wake pin falling edge sets wake bit 0
// RULE_14: host clears flags by writing ones, zeros ignored
// RULE_15: global register shows one pending bit per group
// RULE_16: alert output low while events pending, delay after clear
// RULE_17: transceiver flags except frame error captured only when their enable is set
// RULE_18: flags stay set; event beats simultaneous clear
// RULE_19: reserved status bits read zero, ignore writes
`timescale 1ns/1ns
module sbc_event_status_flags #(
    parameter int EVENT_DELAY_CYCLES_P = sbc_event_pkg::EVENT_DELAY_CYCLES
) (
    input  wire logic                             clk_sys,
    input  wire logic                             reset_n,
    // register port from the serial interface front end
    input  wire logic [sbc_event_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    input  wire logic [sbc_event_pkg::DATA_W-1:0] reg_wdata,
    output logic      [sbc_event_pkg::DATA_W-1:0] reg_rdata,
    // watchdog
    input  wire logic                             wd_overflow,
    input  wire logic                             wd_trigger_early,
    input  wire logic                             wd_mode_window,
    input  wire logic                             wd_mode_timeout,
    output logic                                  sys_reset_req,
    // supplies
    input  wire logic                             sleep_mode,
    input  wire logic                             main_reg_active,
    input  wire logic                             main_reg_below_90,
    input  wire logic                             aux_supply_overvolt,
    input  wire logic                             aux_supply_undervolt,
    // transceiver
    input  wire logic                             selective_wake_frame_error,
    input  wire logic                             bus_active,
    input  wire logic                             bus_silence_timeout,
    input  wire logic                             bus_silence_enable,
    input  wire logic                             transceiver_fail_enable,
    input  wire logic                             bus_wakeup_enable,
    input  wire logic                             can_supply_undervolt_off,
    input  wire logic                             txd_dominant_clamped,
    input  wire logic                             transceiver_offline,
    input  wire logic                             bus_wakeup_detect,
    // wake pin
    input  wire logic                             wake_pin,
    input  wire logic                             wake_rise_enable,
    input  wire logic                             wake_fall_enable,
    // alert to host
    input  wire logic                             reset_pin_low,
    output logic                                  event_alert_n
);
    import sbc_event_pkg::*;

    localparam logic [DELAY_CNT_W-1:0] DELAY_LOAD = DELAY_CNT_W'(EVENT_DELAY_CYCLES_P - 1);

    // ---------------- register decode ----------------
    wire hit_sys  = reg_addr == ADDR_SYSTEM_EVENT;
    wire hit_sup  = reg_addr == ADDR_SUPPLY_EVENT;
    wire hit_trx  = reg_addr == ADDR_TRANSCEIVER_EVENT;
    wire hit_wake = reg_addr == ADDR_WAKE_PIN_EVENT;
    wire hit_glb  = reg_addr == ADDR_GLOBAL_EVENT;

    wire [DATA_W-1:0] clr_sys  = (reg_wr && hit_sys) ? reg_wdata : 8'h00; // [RULE_14]
    wire [DATA_W-1:0] clr_sup  = (reg_wr && hit_sup) ? reg_wdata : 8'h00; // [RULE_14]
    wire [DATA_W-1:0] clr_trx  = (reg_wr && hit_trx) ? reg_wdata : 8'h00; // [RULE_14]
    wire [DATA_W-1:0] clr_wake = (reg_wr && hit_wake) ? reg_wdata : 8'h00; // [RULE_14]

    logic [DATA_W-1:0] sys_flags;
    logic [DATA_W-1:0] sup_flags;
    logic [DATA_W-1:0] trx_flags;
    logic [DATA_W-1:0] wake_flags;

    // ---------------- watchdog ----------------
    wire wd_window_fail  = wd_mode_window && (wd_overflow || wd_trigger_early);
    wire wd_timeout_over = wd_mode_timeout && wd_overflow;
    wire wd_fail_event   = wd_window_fail || wd_timeout_over; // [RULE_01]
    // the already-set test looks at the stored flag, before this event lands
    wire wd_reset_next   = wd_window_fail // [RULE_02]
                         || (wd_timeout_over && sys_flags[SYS_WATCHDOG_FAIL_BIT]); // [RULE_03]

    logic sys_reset_req_reg;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sys_reset_req_reg <= 1'b0;
        end else begin
            sys_reset_req_reg <= wd_reset_next;
        end
    end
    assign sys_reset_req = sys_reset_req_reg;

    wire [DATA_W-1:0] sys_set = DATA_W'(wd_fail_event) << SYS_WATCHDOG_FAIL_BIT; // [RULE_01]

    // ---------------- supplies ----------------
    // no threshold-control input on purpose: capture must not depend on it
    wire main_uv_event = main_reg_below_90 && main_reg_active && !sleep_mode; // [RULE_06] [RULE_07]

    wire [DATA_W-1:0] sup_set = (DATA_W'(main_uv_event) << SUP_MAIN_UNDERVOLT_BIT)
                              | (DATA_W'(aux_supply_undervolt) << SUP_AUX_UNDERVOLT_BIT) // [RULE_05]
                              | (DATA_W'(aux_supply_overvolt) << SUP_AUX_OVERVOLT_BIT); // [RULE_04]

    // ---------------- transceiver ----------------
    // silence detection arms only once enabled while the bus is active
    logic silence_armed_reg;
    wire  silence_armed_next = !bus_silence_enable ? 1'b0 :
                               bus_active ? 1'b1 :
                               bus_silence_timeout ? 1'b0 : silence_armed_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            silence_armed_reg <= 1'b0;
        end else begin
            silence_armed_reg <= silence_armed_next; // [RULE_09]
        end
    end

    wire silence_event = bus_silence_timeout && silence_armed_reg && bus_silence_enable && !bus_active; // [RULE_09] [RULE_17]
    wire trx_fail_event = (can_supply_undervolt_off || txd_dominant_clamped)
                        && !sleep_mode && transceiver_fail_enable; // [RULE_10] [RULE_17]
    wire wakeup_event = bus_wakeup_detect && transceiver_offline && bus_wakeup_enable; // [RULE_11] [RULE_17]

    wire [DATA_W-1:0] trx_set = (DATA_W'(wakeup_event) << TRX_BUS_WAKEUP_BIT)
                              | (DATA_W'(trx_fail_event) << TRX_FAIL_BIT)
                              | (DATA_W'(silence_event) << TRX_BUS_SILENCE_BIT)
                              | (DATA_W'(selective_wake_frame_error) << TRX_FRAME_ERROR_BIT); // [RULE_08]

    // the silence bit is a bus status: it reads 0 whenever the bus is active
    wire [DATA_W-1:0] trx_visible = trx_flags
                                  & ~(DATA_W'(bus_active) << TRX_BUS_SILENCE_BIT); // [RULE_09]

    // ---------------- wake pin ----------------
    logic wake_sync1_reg;
    logic wake_sync2_reg;
    logic wake_prev_reg;
    logic [1:0] wake_prime_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wake_sync1_reg <= 1'b0;
            wake_sync2_reg <= 1'b0;
            wake_prev_reg  <= 1'b0;
        end else begin
            wake_sync1_reg <= wake_pin;
            wake_sync2_reg <= wake_sync1_reg;
            wake_prev_reg  <= wake_sync2_reg;
        end
    end

    // suppress the false edge seen while the synchroniser fills after reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wake_prime_reg <= 2'h0;
        end else if (wake_prime_reg != WAKE_PRIME_CYCLES) begin
            wake_prime_reg <= wake_prime_reg + 2'h1;
        end
    end

    wire wake_primed = wake_prime_reg == WAKE_PRIME_CYCLES;
    wire wake_rise   = wake_primed && wake_sync2_reg && !wake_prev_reg && wake_rise_enable; // [RULE_12]
    wire wake_fall   = wake_primed && !wake_sync2_reg && wake_prev_reg && wake_fall_enable; // [RULE_13]

    wire [DATA_W-1:0] wake_set = (DATA_W'(wake_rise) << WAKE_RISE_BIT)
                               | (DATA_W'(wake_fall) << WAKE_FALL_BIT);

    // ---------------- flag banks ----------------
    event_flag_bank #(.IMPL_MASK(SYS_IMPL_MASK)) u_sys_flags (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .set_in    (sys_set),
        .clear_in  (clr_sys),
        .flags_reg (sys_flags)
    );

    event_flag_bank #(.IMPL_MASK(SUP_IMPL_MASK)) u_sup_flags (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .set_in    (sup_set),
        .clear_in  (clr_sup),
        .flags_reg (sup_flags)
    );

    event_flag_bank #(.IMPL_MASK(TRX_IMPL_MASK)) u_trx_flags (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .set_in    (trx_set),
        .clear_in  (clr_trx),
        .flags_reg (trx_flags)
    );

    event_flag_bank #(.IMPL_MASK(WAKE_IMPL_MASK)) u_wake_flags (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .set_in    (wake_set),
        .clear_in  (clr_wake),
        .flags_reg (wake_flags)
    );

    // ---------------- global summary ----------------
    wire [DATA_W-1:0] global_summary = (DATA_W'(|sys_flags) << GLB_SYSTEM_BIT)
                                     | (DATA_W'(|sup_flags) << GLB_SUPPLY_BIT)
                                     | (DATA_W'(|trx_visible) << GLB_TRANSCEIVER_BIT)
                                     | (DATA_W'(|wake_flags) << GLB_WAKE_PIN_BIT); // [RULE_15]
    wire any_pending = |global_summary;

    // ---------------- read path ----------------
    wire [DATA_W-1:0] read_mux = hit_glb  ? global_summary :
                                 hit_sys  ? sys_flags :
                                 hit_sup  ? sup_flags :
                                 hit_trx  ? trx_visible :
                                 hit_wake ? wake_flags : UNMAPPED_READ; // [RULE_19]

    logic [DATA_W-1:0] reg_rdata_reg;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_reg <= read_mux;
        end
    end
    assign reg_rdata = reg_rdata_reg;

    // ---------------- alert output with event delay ----------------
    // a clear written to any set bit, dropped or re-set by a same-cycle event, releases the alert and starts the delay
    wire clear_hit = |(clr_sys & sys_flags) || |(clr_sup & sup_flags)
                  || |(clr_trx & trx_flags) || |(clr_wake & wake_flags);

    alert_state_t           alert_state_reg;
    alert_state_t           alert_state_next;
    logic [DELAY_CNT_W-1:0] delay_cnt_reg;
    logic                   alert_n_reg;

    wire delay_done = delay_cnt_reg == '0;

    always_comb begin
        alert_state_next = alert_state_reg;
        unique case (alert_state_reg)
            ALERT_IDLE: begin
                // a clear landing before the alert drops must still start the delay, or the pin sticks low
                if (clear_hit) begin
                    alert_state_next = ALERT_HOLD; // [RULE_16]
                end else if (any_pending) begin
                    alert_state_next = ALERT_LOW; // [RULE_16]
                end
            end
            ALERT_LOW: begin
                if (clear_hit) begin
                    alert_state_next = ALERT_HOLD;
                end
            end
            ALERT_HOLD: begin
                // the reset pin going low stops the delay at once
                if (reset_pin_low || (delay_done && !clear_hit)) begin
                    alert_state_next = any_pending ? ALERT_LOW : ALERT_IDLE; // [RULE_16]
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            delay_cnt_reg <= '0;
        end else if (clear_hit) begin
            delay_cnt_reg <= DELAY_LOAD;
        end else if (alert_state_reg == ALERT_HOLD && !delay_done) begin
            delay_cnt_reg <= delay_cnt_reg - DELAY_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alert_state_reg <= ALERT_IDLE;
            alert_n_reg     <= 1'b1;
        end else begin
            alert_state_reg <= alert_state_next;
            alert_n_reg     <= alert_state_next != ALERT_LOW; // [RULE_16]
        end
    end
    assign event_alert_n = alert_n_reg;

endmodule

// ===== shared/sbc_event_pkg.sv
// shared constants for the event status flag block
package sbc_event_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // register addresses on the serial register port
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_EVENT      = 7'h60;
    localparam logic [ADDR_W-1:0] ADDR_SYSTEM_EVENT      = 7'h61;
    localparam logic [ADDR_W-1:0] ADDR_SUPPLY_EVENT      = 7'h62;
    localparam logic [ADDR_W-1:0] ADDR_TRANSCEIVER_EVENT = 7'h63;
    localparam logic [ADDR_W-1:0] ADDR_WAKE_PIN_EVENT    = 7'h64;

    // system event status fields
    localparam int SYS_WATCHDOG_FAIL_BIT = 0;

    // supply event status fields
    localparam int SUP_MAIN_UNDERVOLT_BIT = 0;
    localparam int SUP_AUX_UNDERVOLT_BIT  = 1;
    localparam int SUP_AUX_OVERVOLT_BIT   = 2;

    // transceiver event status fields
    localparam int TRX_BUS_WAKEUP_BIT  = 0;
    localparam int TRX_FAIL_BIT        = 1;
    localparam int TRX_BUS_SILENCE_BIT = 4;
    localparam int TRX_FRAME_ERROR_BIT = 5;

    // wake pin event status fields
    localparam int WAKE_FALL_BIT = 0;
    localparam int WAKE_RISE_BIT = 1;

    // global summary fields
    localparam int GLB_SYSTEM_BIT      = 0;
    localparam int GLB_SUPPLY_BIT      = 1;
    localparam int GLB_TRANSCEIVER_BIT = 2;
    localparam int GLB_WAKE_PIN_BIT    = 3;

    // implemented bits per status register; the rest read as zero
    localparam logic [DATA_W-1:0] SYS_IMPL_MASK  = 8'h01;
    localparam logic [DATA_W-1:0] SUP_IMPL_MASK  = 8'h07;
    localparam logic [DATA_W-1:0] TRX_IMPL_MASK  = 8'h33;
    localparam logic [DATA_W-1:0] WAKE_IMPL_MASK = 8'h03;

    localparam logic [DATA_W-1:0] FLAGS_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // event delay timing
    localparam int CLK_FREQ_MHZ       = 125;
    localparam int EVENT_DELAY_US     = 1000;
    localparam int EVENT_DELAY_CYCLES = EVENT_DELAY_US * CLK_FREQ_MHZ;
    localparam int DELAY_CNT_W        = 20;

    // wake input settle time after reset, in cycles
    localparam logic [1:0] WAKE_PRIME_CYCLES = 2'h3;

    typedef enum logic [2:0] {
        ALERT_IDLE = 3'b001,
        ALERT_LOW  = 3'b010,
        ALERT_HOLD = 3'b100
    } alert_state_t;

endpackage

// ===== src/event_flag_bank.sv
// bank of sticky write-one-to-clear event flags
`timescale 1ns/1ns
module event_flag_bank #(
    parameter logic [7:0] IMPL_MASK = 8'hff
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [7:0] set_in,
    input  wire logic [7:0] clear_in,
    output logic      [7:0] flags_reg
);
    import sbc_event_pkg::*;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            if (IMPL_MASK[i]) begin : g_impl
                always_ff @(posedge clk_sys or negedge reset_n) begin
                    if (!reset_n) begin
                        flags_reg[i] <= FLAGS_RESET[i];
                    end else if (set_in[i]) begin
                        // a new event wins over a clear in the same cycle
                        flags_reg[i] <= 1'b1; // [RULE_18]
                    end else if (clear_in[i]) begin
                        flags_reg[i] <= 1'b0; // [RULE_14]
                    end
                end
            end else begin : g_resv
                assign flags_reg[i] = 1'b0; // [RULE_19]
            end
        end
    endgenerate

endmodule

// ===== bench/event_host_model.sv
// host side of the register strobe port: single reads and clearing writes
`timescale 1ns/1ns
module event_host_model (
    input  wire logic                             clk_sys,
    output logic      [sbc_event_pkg::ADDR_W-1:0] reg_addr,
    output logic                                  reg_wr,
    output logic                                  reg_rd,
    output logic      [sbc_event_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic [sbc_event_pkg::DATA_W-1:0] reg_rdata
);
    import sbc_event_pkg::*;

    initial begin
        reg_addr  = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = '0;
    end

    // one strobe cycle; the port is parked inverted so a stale address never looks valid
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [7:0] q);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = !w;
        @(negedge clk_sys);
        q         = reg_rdata;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        @(negedge clk_sys);
    endtask
endmodule

// ===== bench/sbc_event_status_flags_chk.sv
// concurrent checks on the event flag block ports
`timescale 1ns/1ns
module sbc_event_status_flags_chk #(
    parameter int EVENT_DELAY_CYCLES_P = 8
) (
    input wire logic                             clk_sys,
    input wire logic                             reset_n,
    input wire logic [sbc_event_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                             reg_wr,
    input wire logic                             reg_rd,
    input wire logic [sbc_event_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [sbc_event_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                             wd_overflow,
    input wire logic                             wd_trigger_early,
    input wire logic                             wd_mode_window,
    input wire logic                             wd_mode_timeout,
    input wire logic                             sys_reset_req,
    input wire logic                             reset_pin_low,
    input wire logic                             event_alert_n
);
    import sbc_event_pkg::*;
    logic wdf_m;
    wire logic wd_ev  = (wd_overflow && (wd_mode_window || wd_mode_timeout)) || (wd_trigger_early && wd_mode_window);
    wire logic wd_clr = reg_wr && reg_addr == ADDR_SYSTEM_EVENT && reg_wdata[SYS_WATCHDOG_FAIL_BIT];
    wire logic rd_unmapped = reg_rd && !(reg_addr inside {[ADDR_GLOBAL_EVENT:ADDR_WAKE_PIN_EVENT]});

    // shadow of the watchdog flag so the timeout reset policy can be judged from the ports
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wdf_m <= 1'b0;
        end else begin
            wdf_m <= wd_ev | (wdf_m & ~wd_clr);
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_win; wd_mode_window && (wd_trigger_early || wd_overflow) |=> sys_reset_req; endproperty
    a_win: assert property (p_win) else $error("no reset request after window failure");
    property p_tmo; wd_mode_timeout && !wd_mode_window && wd_overflow |=> sys_reset_req == $past(wdf_m); endproperty
    a_tmo: assert property (p_tmo) else $error("timeout reset does not follow prior flag");
    property p_cause; sys_reset_req |-> $past(wd_overflow || wd_trigger_early); endproperty
    a_cause: assert property (p_cause) else $error("reset request without watchdog event");
    property p_wdf; reg_rd && reg_addr == ADDR_SYSTEM_EVENT |=> reg_rdata[0] == $past(wdf_m); endproperty
    a_wdf: assert property (p_wdf) else $error("watchdog flag read wrong");
    property p_trx_rsv; reg_rd && reg_addr == ADDR_TRANSCEIVER_EVENT |=> (reg_rdata & ~TRX_IMPL_MASK) == 8'h00; endproperty
    a_trx_rsv: assert property (p_trx_rsv) else $error("reserved transceiver bits set");
    property p_unmap; rd_unmapped |=> reg_rdata == UNMAPPED_READ; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_glb_rsv; reg_rd && reg_addr == ADDR_GLOBAL_EVENT |=> reg_rdata[7:4] == 4'h0; endproperty
    a_glb_rsv: assert property (p_glb_rsv) else $error("reserved summary bits set");
    property p_rel; $rose(event_alert_n) |-> $past(reg_wr); endproperty
    a_rel: assert property (p_rel) else $error("alert released without a write");
    property p_hold; $rose(event_alert_n) && !reset_pin_low ##1 !reset_pin_low [*4] |-> event_alert_n; endproperty
    a_hold: assert property (p_hold) else $error("alert dropped inside event delay");

    c_win: cover property (wd_mode_window && wd_trigger_early ##1 sys_reset_req);
    c_tmo: cover property (wd_mode_timeout && wd_overflow && wdf_m ##1 sys_reset_req);
    c_rel: cover property ($rose(event_alert_n));
endmodule

bind sbc_event_status_flags sbc_event_status_flags_chk #(.EVENT_DELAY_CYCLES_P(EVENT_DELAY_CYCLES_P)) chk_i (
    .clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .wd_overflow, .wd_trigger_early,
    .wd_mode_window, .wd_mode_timeout, .sys_reset_req, .reset_pin_low, .event_alert_n);

// ===== bench/sbc_event_status_flags_tb.sv
// self-checking bench for the event status flag block
`timescale 1ns/1ns
module sbc_event_status_flags_tb;
    import sbc_event_pkg::*;
    localparam int DLY = 40;
    localparam int OVF = 0, ERL = 1, WIN = 2, TMO = 3, SLP = 4, MON = 5, MUV = 6, XOV = 7, XUV = 8, FRE = 9,
                   BAC = 10, SIL = 11, SEN = 12, FEN = 13, WEN = 14, CUV = 15, TXC = 16, OFF = 17, BWU = 18,
                   WKP = 19, WRE = 20, WFE = 21, RPL = 22;
    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic       [22:0] iv = '0;
    logic [ADDR_W-1:0] reg_addr;
    logic              reg_wr, reg_rd, sys_reset_req, event_alert_n;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, q;
    logic       [31:0] seed = 32'h774c;
    int                num_errors = 0;
    int                compares = 0;
    int                m = 0; // model flags: byte 0 system, 1 supply, 2 transceiver, 3 wake pin

    always #4 clk_sys = ~clk_sys;

    sbc_event_status_flags #(.EVENT_DELAY_CYCLES_P(DLY)) sbc_event_status_flags_i (
        .clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .sys_reset_req, .event_alert_n,
        .wd_overflow(iv[OVF]), .wd_trigger_early(iv[ERL]), .wd_mode_window(iv[WIN]), .wd_mode_timeout(iv[TMO]),
        .sleep_mode(iv[SLP]), .main_reg_active(iv[MON]), .main_reg_below_90(iv[MUV]), .aux_supply_overvolt(iv[XOV]),
        .aux_supply_undervolt(iv[XUV]), .selective_wake_frame_error(iv[FRE]), .bus_active(iv[BAC]),
        .bus_silence_timeout(iv[SIL]), .bus_silence_enable(iv[SEN]), .transceiver_fail_enable(iv[FEN]),
        .bus_wakeup_enable(iv[WEN]), .can_supply_undervolt_off(iv[CUV]), .txd_dominant_clamped(iv[TXC]),
        .transceiver_offline(iv[OFF]), .bus_wakeup_detect(iv[BWU]), .wake_pin(iv[WKP]), .wake_rise_enable(iv[WRE]),
        .wake_fall_enable(iv[WFE]), .reset_pin_low(iv[RPL]));
    event_host_model event_host_model_i (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick;
        @(negedge clk_sys);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results;
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one-cycle event; the reset request stands only in the following cycle, so it is sampled there
    task automatic pulse(input int b, input int mk, input logic rs);
        iv = iv | b[22:0];
        tick;
        chk({7'h0, sys_reset_req}, {7'h0, rs}, "reset request");
        iv = iv & ~b[22:0];
        m = m | mk;
        tick;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        event_host_model_i.xfer(1'b1, a, d, q);
        if (a inside {[7'h61:7'h64]}) m = m & ~(int'(d) << (8 * (a - 7'h61)));
    endtask

    // supply register first, so a read lands right behind a fresh supply event
    task automatic rd_all;
        logic [6:0] a;
        logic [7:0] e;
        for (int k = 0; k < 6; k++) begin
            a = 7'h60 + 7'((k + 2) % 6);
            e = (a == 7'h65) ? 8'h00 : (a == 7'h60) ? {4'h0, |m[31:24], |m[23:16], |m[15:8], |m[7:0]} : 8'(m >> (8 * (a - 7'h61)));
            event_host_model_i.xfer(1'b0, a, 8'h00, q);
            chk(q, e, "register read");
        end
    endtask

    task automatic wait_alert(input logic v);
        int k;
        for (k = 0; k < DLY + 20 && event_alert_n !== v; k++) tick;
        chk({7'h0, event_alert_n}, {7'h0, v}, "alert");
        if (event_alert_n !== v) results;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        chk(8'h00, 8'h01, "run timeout");
        results;
    end

    initial begin
        repeat (16) tick;
        reset_n = 1'b1;
        repeat (4) tick;
        wait_alert(1'b1);
        rd_all;
        iv = iv | 23'((1 << MON) | (1 << SEN) | (1 << FEN) | (1 << WEN) | (1 << WRE) | (1 << WFE));
        pulse(1 << FRE, 32'h0020_0000, 1'b0);
        wait_alert(1'b0);
        wr(ADDR_TRANSCEIVER_EVENT, 8'h20);
        wait_alert(1'b1);
        pulse(1 << XOV, 32'h0000_0400, 1'b0);
        wait_alert(1'b1);
        wait_alert(1'b0);
        wr(ADDR_SUPPLY_EVENT, 8'h04);
        repeat (DLY + 4) tick;
        wait_alert(1'b1);
        fork
            pulse(1 << XUV, 32'h0000_0200, 1'b0);
            begin
                tick;
                wr(ADDR_SUPPLY_EVENT, 8'h02);
            end
        join
        wait_alert(1'b1);
        pulse((1 << XOV) | (1 << XUV), 32'h0000_0600, 1'b0);
        wr(ADDR_SUPPLY_EVENT, 8'h04);
        iv[RPL] = 1'b1;
        repeat (3) tick;
        chk({7'h0, event_alert_n}, 8'h00, "alert after reset pin");
        iv[RPL] = 1'b0;
        wr(ADDR_SUPPLY_EVENT, 8'hff);
        iv[TMO] = 1'b1;
        pulse(1 << ERL, 0, 1'b0);
        pulse(1 << OVF, 1, m[0]);
        pulse(1 << OVF, 1, m[0]);
        rd_all;
        wr(ADDR_SYSTEM_EVENT, 8'hff);
        iv[TMO] = 1'b0;
        iv[WIN] = 1'b1;
        pulse(1 << ERL, 1, 1'b1);
        pulse(1 << OVF, 1, 1'b1);
        iv[WIN] = 1'b0;
        iv[SLP] = 1'b1;
        pulse((1 << MUV) | (1 << TXC), 0, 1'b0);
        iv = iv & ~23'((1 << SLP) | (1 << MON) | (1 << FEN));
        pulse((1 << MUV) | (1 << CUV), 0, 1'b0);
        iv = iv | 23'((1 << MON) | (1 << FEN));
        pulse(1 << MUV, 32'h0000_0100, 1'b0);
        rd_all;
        pulse(1 << CUV, 32'h0002_0000, 1'b0);
        wr(ADDR_TRANSCEIVER_EVENT, 8'h02);
        pulse((1 << TXC) | (1 << BWU), 32'h0002_0000, 1'b0);
        iv[OFF] = 1'b1;
        pulse(1 << BWU, 32'h0001_0000, 1'b0);
        pulse(1 << SIL, 0, 1'b0);
        pulse(1 << BAC, 0, 1'b0);
        pulse(1 << SIL, 32'h0010_0000, 1'b0);
        rd_all;
        iv[WKP] = 1'b1;
        // synchroniser plus edge detector latency
        repeat (6) tick;
        iv[WKP] = 1'b0;
        m = m | 32'h0200_0000;
        repeat (6) tick;
        m = m | 32'h0100_0000;
        rd_all;
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            pulse((1 << MUV) | (1 << XOV) | (1 << XUV) | (1 << FRE), 32'h0020_0700, 1'b0);
            wr(7'h60 + 7'(seed[2:0]), seed[15:8]);
            rd_all;
        end
        fork
            wr(ADDR_SUPPLY_EVENT, 8'h04);
            pulse(1 << XOV, 0, 1'b0);
        join
        m = m | 32'h0000_0400;
        rd_all;
        results;
    end
endmodule
